// file: tb/retimer_edge_rate_contention_csr_tb.sv
// bench for the edge-rate and contention register bank
// assumes the host model above; straps and detectors driven here
`timescale 1ns/10ps
module retimer_edge_rate_contention_csr_tb;
    import rtecc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic [1:0] pin = 2'h0;
    logic [1:0] code = 2'h0;
    logic [3:0] cont = 4'h0;
    logic sav, wv, rq, rv;
    logic [7:0] sa, wd, rd;
    logic [1:0] f_in, f_out, f_clk, f3, f2, f1, f0, hs;
    logic [23:0] b3;
    logic bok;
    int num_errors = 0;
    int tests_run = 0;
    logic [7:0] cseq [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0f, 8'h00};
    always #2.5 clk_sys_i = ~clk_sys_i;
    rtecc_host_model host (.clk_sys_i(clk_sys_i), .rd_valid_i(rv), .rd_data_i(rd),
        .sub_addr_valid_o(sav), .sub_addr_o(sa), .wr_valid_o(wv), .wr_data_o(wd),
        .rd_req_o(rq));
    rtecc_csr DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
        .sub_addr_valid_i(sav), .sub_addr_i(sa), .wr_valid_i(wv), .wr_data_i(wd),
        .rd_req_i(rq), .slew_strap_pin_i(pin), .out_lp_strap_code_i(code),
        .out_lane0_neg_contention_i(cont[3]), .out_lane0_pos_contention_i(cont[2]),
        .in_lane0_neg_contention_i(cont[1]), .in_lane0_pos_contention_i(cont[0]),
        .rd_data_o(rd), .rd_valid_o(rv), .in_side_lp_slew_sel_o(f_in),
        .out_side_lp_slew_sel_o(f_out), .clock_lane_hs_slew_sel_o(f_clk),
        .lane3_hs_slew_sel_o(f3), .lane2_hs_slew_sel_o(f2), .lane1_hs_slew_sel_o(f1),
        .lane0_hs_slew_sel_o(f0));
    task automatic test_done;
        if (num_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask
    task automatic rd_next(input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.rd_byte(d, ok);
        if (ok !== 1'b1) begin
            $display("MISMATCH read_answer expected 1 seen 0");
            num_errors++;
            test_done();
        end else begin
            chk("read_byte", exp, d);
        end
    endtask
    task automatic rd_at(input logic [7:0] a, input logic [7:0] exp);
        host.set_ptr(a);
        rd_next(exp);
    endtask
    // enable held low past release so capture waits for a live edge
    task automatic do_reset(input logic [1:0] p, input logic [1:0] c);
        @(negedge clk_sys_i);
        rst_i = 1'b1;
        pin = p;
        code = c;
        repeat (4) @(negedge clk_sys_i);
        chk("fields_in_reset", 8'h00, {f_in, f_out, f_clk, f0} | {2'h0, f3, f2, f1});
        clk_en_i = 1'b0;
        rst_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        clk_en_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
    endtask
    initial begin
        for (int p = 0; p < 4; p++) begin
            do_reset(p[1:0], 2'(3 - p));
            hs = (p == 3) ? 2'h2 : p[1:0];
            rd_at(RTECC_ADDR_SLEW_A, {2'h0, 2'(3 - p), 2'h0, hs});
            rd_next({4{hs}});
            chk("clk_field", {6'h00, hs}, {6'h00, f_clk});
        end
        host.set_ptr(RTECC_ADDR_SLEW_A);
        host.wr_byte(8'hff);
        host.wr_byte(8'h1b);
        host.wr_byte(8'h5a);
        host.wr_byte(8'hff);
        chk("lane_fields", 8'h1b, {f3, f2, f1, f0});
        chk("lp_fields", 8'hff, {f_in, f_out, f_clk, f_clk});
        clk_en_i = 1'b0;
        host.set_ptr(RTECC_ADDR_SLEW_A);
        host.wr_byte(8'h00);
        clk_en_i = 1'b1;
        rd_at(RTECC_ADDR_SLEW_A, 8'hf3);
        rd_next(8'h1b);
        rd_next(8'h00);
        rd_next(8'h00);
        host.burst_rd(RTECC_ADDR_SLEW_A, b3, bok);
        chk("burst_ok", 8'h01, {7'h00, bok});
        chk("burst_byte_a", 8'hf3, b3[23:16]);
        chk("burst_byte_b", 8'h1b, b3[15:8]);
        chk("burst_byte_c", 8'h00, b3[7:0]);
        for (int i = 0; i < 6; i++) begin
            cont = cseq[i][3:0];
            rd_at(RTECC_ADDR_CONT, {2'h0, cont[3:2], 2'h0, cont[1:0]});
        end
        test_done();
    end
endmodule

// file: tb/rtecc_host_model.sv
// host-side byte engine model driving the register port
// assumes one calling process; requests change at the falling edge
`timescale 1ns/10ps
module rtecc_host_model (
    input wire logic clk_sys_i,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    output logic sub_addr_valid_o,
    output logic [7:0] sub_addr_o,
    output logic wr_valid_o,
    output logic [7:0] wr_data_o,
    output logic rd_req_o
);
    initial begin
        sub_addr_valid_o = 1'b0;
        sub_addr_o = 8'h00;
        wr_valid_o = 1'b0;
        wr_data_o = 8'h00;
        rd_req_o = 1'b0;
    end
    // released byte lanes show the inverse, never the last value
    task automatic set_ptr(input logic [7:0] a);
        @(negedge clk_sys_i);
        sub_addr_valid_o = 1'b1;
        sub_addr_o = a;
        @(negedge clk_sys_i);
        sub_addr_valid_o = 1'b0;
        sub_addr_o = ~a;
    endtask
    task automatic wr_byte(input logic [7:0] d);
        @(negedge clk_sys_i);
        wr_valid_o = 1'b1;
        wr_data_o = d;
        @(negedge clk_sys_i);
        wr_valid_o = 1'b0;
        wr_data_o = ~d;
    endtask
    // each byte requested is an acknowledge for the next one
    task automatic rd_byte(output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(negedge clk_sys_i);
        rd_req_o = 1'b1;
        @(negedge clk_sys_i);
        rd_req_o = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rd_valid_i === 1'b1) begin
                ok = 1'b1;
                d = rd_data_i;
            end else begin
                @(negedge clk_sys_i);
            end
        end
    endtask
    // sub-address, then three reads in consecutive cycles without a gap
    task automatic burst_rd(input logic [7:0] a, output logic [23:0] d, output logic ok);
        ok = 1'b1;
        d = 24'h000000;
        @(negedge clk_sys_i);
        sub_addr_valid_o = 1'b1;
        sub_addr_o = a;
        @(negedge clk_sys_i);
        sub_addr_valid_o = 1'b0;
        sub_addr_o = ~a;
        rd_req_o = 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_sys_i);
            ok = ok & (rd_valid_i === 1'b1);
            d = {d[15:0], rd_data_i};
        end
        rd_req_o = 1'b0;
    endtask
endmodule

// file: verilog/rtecc_csr.sv
// edge-rate select and lane-0 contention status register bank
// assumes an i2c engine hands over sub-address, write and read bytes
// one at a time, synchronous to clk_sys_i
`timescale 1ns/10ps
module rtecc_csr
    import rtecc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic sub_addr_valid_i,
    input wire logic [7:0] sub_addr_i,
    input wire logic wr_valid_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_req_i,
    input wire logic [1:0] slew_strap_pin_i,
    input wire logic [1:0] out_lp_strap_code_i,
    input wire logic out_lane0_neg_contention_i,
    input wire logic out_lane0_pos_contention_i,
    input wire logic in_lane0_neg_contention_i,
    input wire logic in_lane0_pos_contention_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic [1:0] in_side_lp_slew_sel_o,
    output logic [1:0] out_side_lp_slew_sel_o,
    output logic [1:0] clock_lane_hs_slew_sel_o,
    output logic [1:0] lane3_hs_slew_sel_o,
    output logic [1:0] lane2_hs_slew_sel_o,
    output logic [1:0] lane1_hs_slew_sel_o,
    output logic [1:0] lane0_hs_slew_sel_o
);
    logic strap_done;
    logic [7:0] ptr;
    logic [3:0] cont;
    logic [1:0] fld [RTECC_NUM_FLD];
    logic [1:0] fld_load_val [RTECC_NUM_FLD];
    wire strap_load;
    wire acc_sub;
    wire acc_wr;
    wire acc_rd;
    wire [1:0] hs_strap_code;
    wire [7:0] reg_slew_a;
    wire [7:0] reg_slew_b;
    wire [7:0] reg_cont;
    wire [7:0] rd_mux;
    wire [7:0] next_ptr;
    wire [3:0] next_cont;

    // first enabled edge after release is the strap capture point
    assign strap_load = clk_en_i & ~strap_done;
    // an undefined pad code is read as high so 11 stays software only in the hs fields
    assign hs_strap_code = (slew_strap_pin_i == RTECC_LVL_BAD) ?
        RTECC_LVL_HIGH : slew_strap_pin_i;

    // sub-address beats write beats read when several arrive together
    assign acc_sub = clk_en_i & sub_addr_valid_i;
    assign acc_wr = clk_en_i & wr_valid_i & ~sub_addr_valid_i & ~strap_load;
    assign acc_rd = clk_en_i & rd_req_i & ~sub_addr_valid_i & ~wr_valid_i & ~strap_load;
    assign next_ptr = acc_sub ? sub_addr_i :
        ((acc_wr | acc_rd) ? 8'(ptr + RTECC_PTR_STEP) : ptr);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            strap_done <= 1'b0;
            ptr <= RTECC_PTR_RST;
        end else if (clk_en_i) begin
            strap_done <= 1'b1;
            ptr <= next_ptr;
        end
    end

    always_comb begin
        fld_load_val[RTECC_IDX_IN_LP] = RTECC_FLD_RST;
        fld_load_val[RTECC_IDX_OUT_LP] = out_lp_strap_code_i;
        fld_load_val[RTECC_IDX_CLK_HS] = hs_strap_code;
        fld_load_val[RTECC_IDX_L3_HS] = hs_strap_code;
        fld_load_val[RTECC_IDX_L2_HS] = hs_strap_code;
        fld_load_val[RTECC_IDX_L1_HS] = hs_strap_code;
        fld_load_val[RTECC_IDX_L0_HS] = hs_strap_code;
    end

    genvar g;
    generate
        for (g = 0; g < RTECC_NUM_FLD; g = g + 1) begin : gen_fld
            wire fld_wr;
            assign fld_wr = acc_wr & (ptr == RTECC_FLD_ADDR[g]);
            rtecc_slew_field u_fld (
                .clk_sys_i(clk_sys_i),
                .rst_i(rst_i),
                .clk_en_i(clk_en_i),
                .load_i(strap_load),
                .load_val_i(fld_load_val[g]),
                .wr_i(fld_wr),
                .wr_val_i(wr_data_i[RTECC_FLD_LSB[g] +: RTECC_FLD_W]),
                .q_o(fld[g])
            );
        end
    endgenerate

    assign in_side_lp_slew_sel_o = fld[RTECC_IDX_IN_LP];
    assign out_side_lp_slew_sel_o = fld[RTECC_IDX_OUT_LP];
    assign clock_lane_hs_slew_sel_o = fld[RTECC_IDX_CLK_HS];
    assign lane3_hs_slew_sel_o = fld[RTECC_IDX_L3_HS];
    assign lane2_hs_slew_sel_o = fld[RTECC_IDX_L2_HS];
    assign lane1_hs_slew_sel_o = fld[RTECC_IDX_L1_HS];
    assign lane0_hs_slew_sel_o = fld[RTECC_IDX_L0_HS];

    // status follows the detectors; nothing the host writes reaches it
    assign next_cont = {out_lane0_neg_contention_i, out_lane0_pos_contention_i,
        in_lane0_neg_contention_i, in_lane0_pos_contention_i};

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cont <= RTECC_CONT_RST;
        end else if (clk_en_i) begin
            cont <= next_cont;
        end
    end

    assign reg_slew_a = {fld[RTECC_IDX_IN_LP], fld[RTECC_IDX_OUT_LP], RTECC_RSVD_2,
        fld[RTECC_IDX_CLK_HS]};
    assign reg_slew_b = {fld[RTECC_IDX_L3_HS], fld[RTECC_IDX_L2_HS],
        fld[RTECC_IDX_L1_HS], fld[RTECC_IDX_L0_HS]};
    assign reg_cont = {RTECC_RSVD_2, cont[3], cont[2], RTECC_RSVD_2,
        cont[1], cont[0]};
    // addresses outside this bank read zero here; other banks mux elsewhere
    assign rd_mux = (ptr == RTECC_ADDR_SLEW_A) ? reg_slew_a :
        (ptr == RTECC_ADDR_SLEW_B) ? reg_slew_b :
        (ptr == RTECC_ADDR_CONT) ? reg_cont : RTECC_RD_RST;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= RTECC_RD_RST;
            rd_valid_o <= 1'b0;
        end else if (clk_en_i) begin
            rd_valid_o <= acc_rd;
            if (acc_rd) begin
                rd_data_o <= rd_mux;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    strap_preload_a: assert property (strap_load |=>
        lane1_hs_slew_sel_o == ($past(slew_strap_pin_i) == RTECC_LVL_BAD ?
            RTECC_LVL_HIGH : $past(slew_strap_pin_i)) &&
        out_side_lp_slew_sel_o == $past(out_lp_strap_code_i) &&
        in_side_lp_slew_sel_o == RTECC_FLD_RST)
        else $error("strap preload value wrong");
    strap_no_eleven_a: assert property (strap_load |=>
        clock_lane_hs_slew_sel_o != 2'h3 && lane0_hs_slew_sel_o != 2'h3)
        else $error("strap produced code 11");
    sw_write_a_a: assert property (acc_wr && ptr == RTECC_ADDR_SLEW_A |=>
        in_side_lp_slew_sel_o == $past(wr_data_i[7:6]) &&
        out_side_lp_slew_sel_o == $past(wr_data_i[5:4]) &&
        clock_lane_hs_slew_sel_o == $past(wr_data_i[1:0]))
        else $error("write to lp_and_clock_edge_rate_ctrl not stored");
    sw_write_b_a: assert property (acc_wr && ptr == RTECC_ADDR_SLEW_B |=>
        lane3_hs_slew_sel_o == $past(wr_data_i[7:6]) &&
        lane2_hs_slew_sel_o == $past(wr_data_i[5:4]) &&
        lane1_hs_slew_sel_o == $past(wr_data_i[3:2]) &&
        lane0_hs_slew_sel_o == $past(wr_data_i[1:0]))
        else $error("write to hs_data_lane_edge_rate_ctrl not stored");
    field_hold_a: assert property (clk_en_i && !strap_load && !acc_wr |=>
        $stable(out_side_lp_slew_sel_o) && $stable(lane2_hs_slew_sel_o))
        else $error("field changed without write");
    auto_inc_a: assert property (acc_rd ##1 (clk_en_i && rd_req_i && !sub_addr_valid_i
        && !wr_valid_i) |=> ptr == $past(ptr, 2) + 8'h02)
        else $error("read pointer did not advance");
    read_answer_a: assert property (acc_rd && ptr == RTECC_ADDR_SLEW_B |=>
        rd_valid_o && rd_data_o == {lane3_hs_slew_sel_o, lane2_hs_slew_sel_o,
            lane1_hs_slew_sel_o, lane0_hs_slew_sel_o})
        else $error("read of hs_data_lane_edge_rate_ctrl wrong");
    status_read_a: assert property (acc_rd && ptr == RTECC_ADDR_CONT |=>
        rd_data_o[7:6] == 2'h0 && rd_data_o[3:2] == 2'h0 &&
        rd_data_o[5] == $past(cont[3]) && rd_data_o[0] == $past(cont[0]))
        else $error("status read wrong");
    status_track_a: assert property (clk_en_i ##1 clk_en_i |=>
        cont == {$past(out_lane0_neg_contention_i), $past(out_lane0_pos_contention_i),
            $past(in_lane0_neg_contention_i), $past(in_lane0_pos_contention_i)})
        else $error("contention status does not track detector");
    resvd_a_a: assert property (acc_rd && ptr == RTECC_ADDR_SLEW_A |=>
        rd_data_o[3:2] == 2'h0)
        else $error("reserved bits of lp_and_clock_edge_rate_ctrl not zero");
    freeze_a: assert property (!clk_en_i |=> $stable(ptr) && $stable(rd_valid_o))
        else $error("state moved while disabled");
    rd_pulse_a: assert property (clk_en_i && !acc_rd |=> !rd_valid_o)
        else $error("read valid outlived its cycle");
    unmapped_read_a: assert property (acc_rd && ptr != RTECC_ADDR_SLEW_A &&
        ptr != RTECC_ADDR_SLEW_B && ptr != RTECC_ADDR_CONT |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    // a write landing on the status byte must leave the in lp, clock hs, lane3 and lane0 fields alone
    status_write_a: assert property (acc_wr && ptr == RTECC_ADDR_CONT |=>
        $stable(in_side_lp_slew_sel_o) && $stable(clock_lane_hs_slew_sel_o) &&
        $stable(lane3_hs_slew_sel_o) && $stable(lane0_hs_slew_sel_o))
        else $error("write to status byte changed a field");

    strap_c: cover property (strap_load ##1 acc_wr);
    burst_read_c: cover property (acc_sub ##1 acc_rd ##1 acc_rd ##1 acc_rd);
    contention_c: cover property (acc_rd && ptr == RTECC_ADDR_CONT && cont != 4'h0);
    sw_eleven_c: cover property (clock_lane_hs_slew_sel_o == 2'h3);
    status_write_c: cover property (acc_wr && ptr == RTECC_ADDR_CONT);
endmodule

// file: verilog/rtecc_pkg.sv
// shared constants of the edge-rate and contention register bank
// assumes 8-bit registers reached through a byte-wide sub-address port
package rtecc_pkg;
    localparam logic [7:0] RTECC_ADDR_SLEW_A = 8'h0a;
    localparam logic [7:0] RTECC_ADDR_SLEW_B = 8'h0b;
    localparam logic [7:0] RTECC_ADDR_CONT = 8'h0d;
    localparam logic [7:0] RTECC_PTR_RST = 8'h00;
    localparam logic [7:0] RTECC_PTR_STEP = 8'h01;
    localparam logic [7:0] RTECC_RD_RST = 8'h00;
    localparam logic [1:0] RTECC_FLD_RST = 2'h0;
    localparam logic [1:0] RTECC_RSVD_2 = 2'h0;
    localparam logic [3:0] RTECC_CONT_RST = 4'h0;
    // three-level strap codes as delivered by the pad comparator
    localparam logic [1:0] RTECC_LVL_HIGH = 2'h2;
    localparam logic [1:0] RTECC_LVL_BAD = 2'h3;
    // field order: in lp, out lp, clock hs, lane3, lane2, lane1, lane0
    localparam int RTECC_NUM_FLD = 7;
    localparam int RTECC_FLD_W = 2;
    localparam int RTECC_IDX_IN_LP = 0;
    localparam int RTECC_IDX_OUT_LP = 1;
    localparam int RTECC_IDX_CLK_HS = 2;
    localparam int RTECC_IDX_L3_HS = 3;
    localparam int RTECC_IDX_L2_HS = 4;
    localparam int RTECC_IDX_L1_HS = 5;
    localparam int RTECC_IDX_L0_HS = 6;
    localparam logic [7:0] RTECC_FLD_ADDR [RTECC_NUM_FLD] = '{
        8'h0a, 8'h0a, 8'h0a, 8'h0b, 8'h0b, 8'h0b, 8'h0b};
    localparam int RTECC_FLD_LSB [RTECC_NUM_FLD] = '{6, 4, 0, 6, 4, 2, 0};
    // contention status bit positions inside the status register
    localparam int RTECC_CB_OUT_NEG = 5;
    localparam int RTECC_CB_OUT_POS = 4;
    localparam int RTECC_CB_IN_NEG = 1;
    localparam int RTECC_CB_IN_POS = 0;
endpackage

// file: verilog/rtecc_slew_field.sv
// one two-bit edge-rate field: strap preload, then software owned
// assumes load and write never need to coexist after the preload cycle
`timescale 1ns/10ps
module rtecc_slew_field
    import rtecc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic load_i,
    input wire logic [1:0] load_val_i,
    input wire logic wr_i,
    input wire logic [1:0] wr_val_i,
    output logic [1:0] q_o
);
    logic [1:0] next_q;

    // preload wins: host writes and reads are held off during that one cycle
    assign next_q = load_i ? load_val_i : (wr_i ? wr_val_i : q_o);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            q_o <= RTECC_FLD_RST;
        end else if (clk_en_i) begin
            q_o <= next_q;
        end
    end
endmodule
